// >>> logic/ecu_exception_control.sv
// exception control: request latch, arbitration, mask, break and status registers
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns

module ecu_exception_control (
    input  wire logic                     hclk,          // bus clock
    input  wire logic                     hresetn,       // internal reset, active low
    input  wire logic                     clk_en,        // freezes all state when low
    input  wire logic                     hsel,          // slave select
    input  wire logic [31:0]              haddr,         // byte address
    input  wire logic [1:0]               htrans,        // transfer type
    input  wire logic                     hwrite,        // write when high
    input  wire logic [2:0]               hsize,         // transfer size
    input  wire logic                     hready,        // bus ready in
    input  wire logic [31:0]              hwdata,        // write data
    output logic      [31:0]              hrdata,        // read data
    output logic                          hreadyout,     // slave ready
    output logic                          hresp,         // always okay
    input  wire logic [20:1]              irq_req,       // live peripheral requests
    input  wire logic [20:1]              irq_enable,    // per-source enable bits
    input  wire logic                     break_req,     // break module request
    input  wire ecu_pkg::ecu_core_evt_type core_evt,     // core instruction events
    output ecu_pkg::ecu_entry_type        entry,         // interrupt entry to core
    output logic                          restore_regs,  // one cycle: unstack registers
    output logic                          i_mask,        // interrupt mask level
    output logic                          core_clk_hold, // core clock stopped
    output logic                          break_state,   // core in break
    output logic                          flag_clear_ok  // peripheral flags may clear
);
    typedef enum logic [1:0] {ST_RUN, ST_LATCHED, ST_LOWPWR} ecu_state_type;

    ecu_state_type         state_ff;
    logic [4:0]            latched_vec_ff;
    logic                  i_mask_ff;
    logic                  break_ff;
    logic                  after_rti_ff;
    logic [7:0]            break_ctrl_ff;
    logic [20:1]           flag_ff;
    ecu_pkg::ecu_entry_type entry_ff;
    logic                  restore_ff;
    logic                  wr_pend_ff;
    logic [15:0]           wr_idx_ff;
    logic [31:0]           hrdata_ff;

    logic [20:1]           pending;
    logic [4:0]            winner;
    logic                  any_pending;
    logic                  addr_ok;
    logic [15:0]           idx;
    logic [7:0]            rd_byte;
    logic [31:0]           rd_word;
    logic                  boundary;
    logic                  brk_entry;
    logic                  swi_entry;

    // fixed priority pick
    // index 1 is highest, so the loop runs downward and the last hit wins
    always_comb begin
        winner = 5'h00;
        for (int i = ecu_pkg::NUM_SRC; i >= 1; i--) begin
            if (pending[i]) begin
                winner = 5'(i);
            end
        end
    end

    assign pending     = irq_req & irq_enable;
    assign any_pending = |pending;
    assign boundary    = clk_en && core_evt.insn_done && (state_ff == ST_RUN);
    // break wins over all interrupt sources at a run-state boundary; in low power an enabled unmasked request wins
    assign brk_entry   = boundary && break_req;
    assign swi_entry   = boundary && !break_req && core_evt.swi_op;

    // resets are the asynchronous hresetn alone and are never arbitrated
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff       <= ST_RUN;
            latched_vec_ff <= ecu_pkg::VEC_SWI;
        end else if (clk_en) begin
            unique case (state_ff)
                ST_RUN: begin
                    // mask clear and enabled source needed
                    // a return that restores a clear mask is itself the boundary
                    if (boundary && !break_req && !core_evt.swi_op && any_pending
                        && (!i_mask_ff || (core_evt.rti_op && core_evt.mask_clr))) begin
                        state_ff       <= ST_LATCHED;
                        latched_vec_ff <= winner;
                    end else if (boundary && !break_req && !core_evt.swi_op
                                 && (core_evt.wait_op || core_evt.stop_op)) begin
                        state_ff <= ST_LOWPWR;
                    end
                end
                ST_LATCHED: begin
                    // held against newer requests; dropped only by mask clear
                    state_ff <= ST_RUN;
                end
                ST_LOWPWR: begin
                    // an enabled request wakes straight into stacking
                    if (any_pending && !i_mask_ff) begin
                        state_ff       <= ST_LATCHED;
                        latched_vec_ff <= winner;
                    end else if (break_req) begin
                        state_ff <= ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            entry_ff <= '0;
        end else if (clk_en) begin
            entry_ff.take <= 1'b0;
            entry_ff.push_index_high <= 1'b0;
            if (brk_entry || swi_entry) begin
                entry_ff.take             <= 1'b1;
                entry_ff.vector           <= ecu_pkg::VEC_SWI;
                entry_ff.pc_minus_one     <= 1'b0;
                entry_ff.discard_prefetch <= after_rti_ff;
            end else if (state_ff == ST_LATCHED && !core_evt.mask_clr) begin
                entry_ff.take             <= 1'b1;
                entry_ff.vector           <= latched_vec_ff;
                entry_ff.pc_minus_one     <= 1'b1;
                // back-to-back service drops the return's prefetch
                entry_ff.discard_prefetch <= after_rti_ff;
            end
        end
    end

    // remember that the instruction just finished was a return
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            after_rti_ff <= 1'b0;
        end else if (clk_en && core_evt.insn_done) begin
            after_rti_ff <= core_evt.rti_op;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            restore_ff <= 1'b0;
        end else if (clk_en) begin
            restore_ff <= core_evt.insn_done && core_evt.rti_op;
        end
    end

    // interrupt mask; entry sets it, low power clears it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            i_mask_ff <= ecu_pkg::MASK_RST;
        end else if (clk_en) begin
            if (brk_entry || swi_entry
                || (state_ff == ST_LATCHED && !core_evt.mask_clr)) begin
                i_mask_ff <= 1'b1;
            end else if (boundary && (core_evt.wait_op || core_evt.stop_op)) begin
                i_mask_ff <= 1'b0;
            end else if (core_evt.mask_clr) begin
                i_mask_ff <= 1'b0;
            end else if (core_evt.mask_set) begin
                i_mask_ff <= 1'b1;
            end
        end
    end

    // break state lasts from forced entry to the return that ends it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            break_ff <= 1'b0;
        end else if (clk_en) begin
            if (brk_entry) begin
                break_ff <= 1'b1;
            end else if (core_evt.insn_done && core_evt.rti_op) begin
                break_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_ff <= '0;
        end else if (clk_en) begin
            flag_ff <= irq_req;
        end
    end

    // bus: zero-wait slave; reads answered from a flop in the data phase
    assign idx     = haddr[ecu_pkg::IDX_MSB:ecu_pkg::IDX_LSB];
    assign addr_ok = hsel && hready && (htrans == ecu_pkg::HTRANS_NONSEQ)
                     && (haddr[31:ecu_pkg::IDX_MSB+1] == '0) && (haddr[1:0] == 2'h0);

    always_comb begin
        rd_byte = 8'h00;
        rd_word = 32'h0000_0000;
        unique case (idx)
            ecu_pkg::IDX_BREAK_CTRL:  rd_byte = break_ctrl_ff;
            // flags 6..1 high, bits 1..0 zero
            ecu_pkg::IDX_PEND_LOW:    rd_byte = {flag_ff[6:1], 2'h0};
            ecu_pkg::IDX_PEND_MID:    rd_byte = flag_ff[14:7];
            ecu_pkg::IDX_PEND_HIGH:   rd_byte = {2'h0, flag_ff[20:15]};
            ecu_pkg::IDX_CORE_STATUS: begin
                rd_word[ecu_pkg::ST_MASK_BIT]    = i_mask_ff;
                rd_word[ecu_pkg::ST_BREAK_BIT]   = break_ff;
                rd_word[ecu_pkg::ST_LOWPWR_BIT]  = (state_ff == ST_LOWPWR);
                rd_word[ecu_pkg::ST_LATCHED_BIT] = (state_ff == ST_LATCHED);
                rd_word[ecu_pkg::ST_VEC_LSB +: ecu_pkg::VEC_W] = entry_ff.vector;
            end
            default:                  rd_byte = 8'h00;
        endcase
        rd_word[7:0] = rd_word[7:0] | rd_byte;
    end

    // reads change nothing but the data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (clk_en && addr_ok && !hwrite) begin
            hrdata_ff <= rd_word;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff  <= 16'h0000;
        end else if (clk_en) begin
            wr_pend_ff <= addr_ok && hwrite && (hsize == ecu_pkg::HSIZE_WORD);
            wr_idx_ff  <= idx;
        end
    end

    // only the clear enable bit is writable; status registers ignore writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            break_ctrl_ff <= ecu_pkg::BREAK_CTRL_RST;
        end else if (clk_en && wr_pend_ff && (wr_idx_ff == ecu_pkg::IDX_BREAK_CTRL)) begin
            break_ctrl_ff[ecu_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT] <= hwdata[ecu_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT];
        end
    end

    assign hrdata        = hrdata_ff;
    assign hreadyout     = 1'b1;
    assign hresp         = ecu_pkg::HRESP_OKAY;
    assign entry         = entry_ff;
    assign restore_regs  = restore_ff;
    assign i_mask        = i_mask_ff;
    // core unclocked in wait or stop
    assign core_clk_hold = (state_ff == ST_LOWPWR);
    assign break_state   = break_ff;
    // peripherals gate every clear step with this level
    // a second step seen while protected is simply not honoured, so it stays armed
    assign flag_clear_ok = !break_ff || break_ctrl_ff[ecu_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT];

    AST_TAKE_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
        entry_ff.take |-> i_mask_ff)
        else $error("entry taken without mask set");

    AST_RTI_RESTORE: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && core_evt.insn_done && core_evt.rti_op) |=> restore_ff)
        else $error("return did not restore registers");

    AST_LATCH_HELD: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && state_ff == ST_LATCHED && !core_evt.mask_clr)
        |=> entry_ff.take && entry_ff.vector == $past(latched_vec_ff))
        else $error("latched vector not delivered");

    AST_BOUNDARY_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (clk_en && state_ff == ST_RUN && !core_evt.insn_done) |=> state_ff != ST_LATCHED)
        else $error("request latched mid instruction");

    AST_MASK_BLOCKS: assert property (@(posedge hclk) disable iff (!hresetn)
        (boundary && i_mask_ff && !break_req && !core_evt.swi_op && !core_evt.mask_clr)
        |=> state_ff != ST_LATCHED)
        else $error("request latched while masked");

    AST_PRIORITY: assert property (@(posedge hclk) disable iff (!hresetn)
        (boundary && !i_mask_ff && !break_req && !core_evt.swi_op && pending[1])
        |=> latched_vec_ff == 5'h01 ##1 entry_ff.vector == 5'h01)
        else $error("highest priority source not chosen");

    AST_SWI_ANY_MASK: assert property (@(posedge hclk) disable iff (!hresetn)
        swi_entry |=> entry_ff.take && entry_ff.vector == ecu_pkg::VEC_SWI)
        else $error("software interrupt not taken");

    AST_PC_STACK: assert property (@(posedge hclk) disable iff (!hresetn)
        entry_ff.take |-> entry_ff.pc_minus_one == (entry_ff.vector != ecu_pkg::VEC_SWI))
        else $error("wrong stacked pc kind");

    AST_LOWPWR: assert property (@(posedge hclk) disable iff (!hresetn)
        (boundary && !break_req && !core_evt.swi_op && (i_mask_ff || !any_pending)
         && core_evt.wait_op) |=> core_clk_hold && !i_mask_ff)
        else $error("wait did not hold core or clear mask");

    AST_BREAK_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
        (break_ff && !break_ctrl_ff[ecu_pkg::BREAK_FLAG_CLEAR_ENABLE_BIT]) |-> !flag_clear_ok)
        else $error("flags clearable during protected break");
endmodule

// >>> common/ecu_pkg.sv
// package: constants and carrier types of the exception control unit
package ecu_pkg;
    localparam int          NUM_SRC          = 20;
    localparam int          VEC_W            = 5;
    // register indices; the byte address is four times the index
    localparam logic [15:0] IDX_BREAK_CTRL   = 16'hfe03;
    localparam logic [15:0] IDX_PEND_LOW     = 16'hfe04;
    localparam logic [15:0] IDX_PEND_MID     = 16'hfe05;
    localparam logic [15:0] IDX_PEND_HIGH    = 16'hfe06;
    localparam logic [15:0] IDX_CORE_STATUS  = 16'hfe08;
    localparam int          IDX_LSB          = 2;
    localparam int          IDX_MSB          = 17;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
    localparam logic [2:0]  HSIZE_WORD       = 3'h2;
    localparam logic        HRESP_OKAY       = 1'h0;
    // field positions
    localparam int          BREAK_FLAG_CLEAR_ENABLE_BIT         = 7;
    localparam int          PEND_LOW_LSB     = 2;
    localparam int          ST_MASK_BIT      = 0;
    localparam int          ST_BREAK_BIT     = 1;
    localparam int          ST_LOWPWR_BIT    = 2;
    localparam int          ST_LATCHED_BIT   = 3;
    localparam int          ST_VEC_LSB       = 8;
    // reset values
    localparam logic [7:0]  BREAK_CTRL_RST   = 8'h00;
    localparam logic [7:0]  PEND_RST         = 8'h00;
    localparam logic        MASK_RST         = 1'h1;
    // vector code 0 is the software interrupt vector, 1..20 the maskable sources
    localparam logic [4:0]  VEC_SWI          = 5'h00;

    typedef struct packed {
        logic insn_done;   // current instruction completes this cycle
        logic swi_op;      // completing instruction is a software interrupt
        logic rti_op;      // completing instruction is a return from interrupt
        logic wait_op;     // completing instruction is wait
        logic stop_op;     // completing instruction is stop
        logic mask_set;    // core sets the interrupt mask
        logic mask_clr;    // core clears the interrupt mask
    } ecu_core_evt_type;

    typedef struct packed {
        logic       take;             // one cycle: begin stacking now
        logic [4:0] vector;           // vector choice, held until next entry
        logic       pc_minus_one;     // stack pc - 1 (latched sources) or pc (software interrupt and break)
        logic       discard_prefetch; // opcode prefetched by the return is dropped
        logic       push_index_high;  // always 0: high index register is not stacked
    } ecu_entry_type;
endpackage

// >>> bench/ecu_core_model.sv
// core model: turns bench commands into instruction events and tracks the stack
`timescale 1ns/1ns
module ecu_core_model (
    input  wire logic                   hclk,          // bus clock
    input  wire logic                   hresetn,       // reset, active low
    input  wire logic                   cmd_go,        // one cycle: issue a command
    input  wire logic [2:0]             cmd_op,        // 0 plain 1 swi 2 rti 3 wait 4 stop 5 set 6 clr
    input  wire ecu_pkg::ecu_entry_type entry,         // entry from the unit
    input  wire logic                   restore_regs,  // unstack request
    input  wire logic                   core_clk_hold, // core clock stopped
    output ecu_pkg::ecu_core_evt_type   core_evt_ff,   // instruction events
    output logic [3:0]                  depth_ff       // frames on the stack
);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core_evt_ff <= '0;
        end else begin
            core_evt_ff <= '0;
            // a stopped core completes nothing, so commands are dropped there
            if (cmd_go && !core_clk_hold) begin
                core_evt_ff.insn_done <= (cmd_op < 3'h5);
                core_evt_ff.swi_op    <= (cmd_op == 3'h1);
                core_evt_ff.rti_op    <= (cmd_op == 3'h2);
                core_evt_ff.wait_op   <= (cmd_op == 3'h3);
                core_evt_ff.stop_op   <= (cmd_op == 3'h4);
                core_evt_ff.mask_set  <= (cmd_op == 3'h5);
                // returning restores the saved mask, which is clear
                core_evt_ff.mask_clr  <= (cmd_op == 3'h6) || (cmd_op == 3'h2);
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            depth_ff <= 4'h0;
        end else if (entry.take) begin
            depth_ff <= depth_ff + 4'h1;
        end else if (restore_regs) begin
            depth_ff <= depth_ff - 4'h1;
        end
    end
endmodule

// >>> bench/tb.sv
// testbench: status registers, arbitration, break and low-power scenarios
`timescale 1ns/1ns
module tb;
    logic                      hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0]               haddr, hwdata, hrdata, rd, seed;
    logic [1:0]                htrans;
    logic [2:0]                hsize, cmd_op;
    logic [20:1]               irq_req, irq_enable, p, e;
    logic                      break_req, restore_regs, i_mask, core_clk_hold, took, t2;
    logic                      break_state, flag_clear_ok, cmd_go;
    logic [3:0]                depth, d0;
    ecu_pkg::ecu_core_evt_type core_evt;
    ecu_pkg::ecu_entry_type    entry, cap;
    int                        errors, n_tests, cycles;
    assign hready = hreadyout;
    ecu_exception_control u_dut (.hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq_req(irq_req), .irq_enable(irq_enable), .break_req(break_req), .core_evt(core_evt),
        .entry(entry), .restore_regs(restore_regs), .i_mask(i_mask),
        .core_clk_hold(core_clk_hold), .break_state(break_state), .flag_clear_ok(flag_clear_ok));
    ecu_core_model u_core (.hclk(hclk), .hresetn(hresetn), .cmd_go(cmd_go), .cmd_op(cmd_op),
        .entry(entry), .restore_regs(restore_regs), .core_clk_hold(core_clk_hold),
        .core_evt_ff(core_evt), .depth_ff(depth));
    function automatic logic [4:0] winner(input logic [20:1] q);
        logic [4:0] w;
        w = 5'h00;
        for (int i = 20; i >= 1; i--) if (q[i]) w = 5'(i);
        return w;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    // single word transfer; the wait on hready is bounded
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
        int t;
        t = 0;
        hsel <= 1'b1;
        htrans <= ecu_pkg::HTRANS_NONSEQ;
        haddr <= {14'h0000, idx, 2'h0};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1 && t < 50) begin
            @(posedge hclk);
            t++;
        end
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1 && t < 100) begin
            @(posedge hclk);
            t++;
        end
        rd = hrdata;
        chk("hresp", 32'(ecu_pkg::HRESP_OKAY), 32'(hresp));
    endtask
    // issue one core command, watch six edges for an entry
    task automatic op(input logic [2:0] o, input logic [20:1] late, output logic tk);
        cmd_go <= 1'b1;
        cmd_op <= o;
        tk = 1'b0;
        @(posedge hclk);
        cmd_go <= 1'b0;
        for (int t = 0; t < 6; t++) begin
            @(posedge hclk);
            if (t == 2) irq_req <= late;
            if (entry.take === 1'b1) begin
                tk = 1'b1;
                cap = entry;
            end
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // generous ceiling: the scenarios need about 370 cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, cmd_go, break_req} = '0;
        {haddr, hwdata, htrans, cmd_op, irq_req, irq_enable} = '0;
        hsize = ecu_pkg::HSIZE_WORD;
        seed = 32'h231f950b;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("reset mask", 32'h1, 32'(i_mask));
        chk("reset entry", 32'h0, 32'(entry));
        bus(1'b0, ecu_pkg::IDX_BREAK_CTRL, 32'h0);
        chk("break_flag_clear_enable reset", 32'h0, rd);
        bus(1'b0, ecu_pkg::IDX_PEND_MID, 32'h0);
        chk("mid reset", 32'h0, rd);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            irq_req <= 20'($random(seed));
            @(posedge hclk);
            p = irq_req;
            bus(1'b0, ecu_pkg::IDX_PEND_LOW, 32'h0);
            chk("pend low", {24'h0, p[6:1], 2'h0}, rd);
            bus(1'b1, ecu_pkg::IDX_PEND_MID, 32'($random(seed)));
            bus(1'b0, ecu_pkg::IDX_PEND_MID, 32'h0);
            chk("pend mid", {24'h0, p[14:7]}, rd);
            bus(1'b0, ecu_pkg::IDX_PEND_HIGH, 32'h0);
            chk("pend high", {26'h0, p[20:15]}, rd);
        end
        bus(1'b0, 16'hfe07, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test status done");
        for (int k = 0; k < 8; k++) begin
            p = 20'($random(seed)) | 20'h80000;
            e = 20'($random(seed)) | 20'h80000 | 20'(k == 0);
            if (k == 0) p[1] = 1'b0;
            irq_req <= p;
            irq_enable <= e;
            op(3'h6, p, took);
            op(3'h0, p | 20'(k == 0), took);
            chk("taken", 32'h1, 32'(took));
            chk("vector", 32'(winner(p & e)), 32'(cap.vector));
            chk("pc minus one", 32'h1, 32'(cap.pc_minus_one));
            chk("index high", 32'h0, 32'(cap.push_index_high));
            chk("mask on entry", 32'h1, 32'(i_mask));
            irq_req <= '0;
            op(3'h2, 20'h0, took);
        end
        $display("test arbitration done");
        irq_req <= 20'h00012;
        irq_enable <= '1;
        op(3'h5, 20'h00012, took);
        op(3'h0, 20'h00012, took);
        chk("masked", 32'h0, 32'(took));
        irq_enable <= '0;
        op(3'h6, 20'h00012, took);
        op(3'h0, 20'h00012, took);
        chk("disabled", 32'h0, 32'(took));
        irq_enable <= '1;
        d0 = depth;
        op(3'h0, 20'h00012, took);
        chk("first", 32'h2, 32'(cap.vector));
        irq_req <= 20'h00010;
        op(3'h2, 20'h00010, took);
        op(3'h0, 20'h00010, t2);
        chk("pending at return", 32'h5, 32'(cap.vector));
        chk("discard", 32'h1, 32'(cap.discard_prefetch));
        chk("depth", 32'(d0 + 4'h1), 32'(depth));
        irq_req <= '0;
        op(3'h2, 20'h0, took);
        op(3'h5, 20'h0, took);
        op(3'h1, 20'h0, took);
        chk("swi masked", 32'h1, 32'(took));
        chk("swi vector", 32'(ecu_pkg::VEC_SWI), 32'(cap.vector));
        chk("swi pc", 32'h0, 32'(cap.pc_minus_one));
        op(3'h2, 20'h0, took);
        $display("test mask and return done");
        break_req <= 1'b1;
        op(3'h0, 20'h0, took);
        break_req <= 1'b0;
        chk("break vector", 32'(ecu_pkg::VEC_SWI), 32'(cap.vector));
        chk("break state", 32'h1, 32'(break_state));
        chk("flags guarded", 32'h0, 32'(flag_clear_ok));
        bus(1'b1, ecu_pkg::IDX_BREAK_CTRL, 32'h80);
        bus(1'b0, ecu_pkg::IDX_BREAK_CTRL, 32'h0);
        chk("break_flag_clear_enable rw", 32'h80, rd);
        chk("flags clearable", 32'h1, 32'(flag_clear_ok));
        bus(1'b1, ecu_pkg::IDX_BREAK_CTRL, 32'h0);
        @(posedge hclk);
        chk("guarded again", 32'h0, 32'(flag_clear_ok));
        op(3'h2, 20'h0, took);
        chk("break left", 32'h0, 32'(break_state));
        chk("clear after break", 32'h1, 32'(flag_clear_ok));
        $display("test break done");
        for (int o = 3; o <= 4; o++) begin
            op(3'h5, 20'h0, took);
            op(3'(o), 20'h0, took);
            chk("clock held", 32'h1, 32'(core_clk_hold));
            chk("mask cleared", 32'h0, 32'(i_mask));
            irq_req <= 20'h00100;
            op(3'h0, 20'h00100, took);
            chk("wake take", 32'h1, 32'(took));
            chk("wake vector", 32'h9, 32'(cap.vector));
            chk("clock back", 32'h0, 32'(core_clk_hold));
            irq_req <= '0;
            op(3'h2, 20'h0, took);
        end
        $display("test low power done");
        complete_run();
    end
endmodule
